/* rtl/sfa_pkg.sv */
// shared constants for the serial flash array access block
`default_nettype none
package sfa_pkg;
   // ***************************************
   // command opcodes
   // ***************************************
   localparam logic [7:0] OP_READ    = 8'h52; // read array bytes
   localparam logic [7:0] OP_WRITE   = 8'h82; // load sram, then program sector
   localparam logic [7:0] OP_XFER    = 8'h88; // program sector from sram
   localparam logic [7:0] OP_SRAM_WR = 8'h84; // write sram bytes
   localparam logic [7:0] OP_SRAM_RD = 8'h54; // read sram bytes
   localparam logic [7:0] OP_STATUS  = 8'h57; // read status byte

   // ***************************************
   // geometry
   // ***************************************
   localparam int unsigned SECT_W     = 11;
   localparam int unsigned OFF_W      = 9;
   localparam logic [11:0] SECT_SMALL = 12'h200;  // 512 sectors
   localparam logic [11:0] SECT_LARGE = 12'h800;  // 2048 sectors
   localparam logic [8:0]  OFF_LAST   = 9'h107;   // byte 263
   localparam logic [11:0] BLK_SECT   = 12'h020;  // protect block of 32
   localparam logic [2:0]  ADDR_BYTES = 3'h4;     // address bytes after opcode

   // ***************************************
   // configuration word layout
   // ***************************************
   localparam int unsigned CFG_W      = 9;
   localparam int unsigned CFG_PIN_LSB = 0;  // pin mode, two bits
   localparam int unsigned CFG_RCE    = 2;   // read_edge_select
   localparam int unsigned CFG_WD     = 3;   // protect from top when set
   localparam int unsigned CFG_WR_LSB = 4;   // protect range, four bits
   localparam logic [1:0] PIN_HOLD    = 2'h0;
   localparam logic [1:0] PIN_NC      = 2'h1;
   localparam logic [1:0] PIN_RB      = 2'h2;

   // ***************************************
   // status byte and reset values
   // ***************************************
   localparam int unsigned ST_BUSY    = 0;
   localparam int unsigned ST_WR_REF  = 1;
   localparam int unsigned ST_RD_REF  = 2;
   localparam logic [5:0]  SYNC_RST   = 6'h1A; // sck0 cs1 si0 wp1 hold1 large0

   // ***************************************
   // timing
   // ***************************************
   localparam int unsigned CLK_MHZ    = 200;
   localparam int unsigned TWP_MS     = 5;
   localparam int unsigned TWP_CYCLES = TWP_MS * 1000 * CLK_MHZ;
   localparam int unsigned BUSY_W     = 20;
endpackage : sfa_pkg
`default_nettype wire

/* rtl/sfa_buf2.sv */
// two-entry byte buffer with valid and ready on both sides
`default_nettype none
module sfa_buf2 (
   input  wire logic       clk,       // system clock
   input  wire logic       rst_n,     // sync reset, active low
   input  wire logic       flush,     // drop all entries
   input  wire logic       in_valid,  // write side valid
   output logic            in_ready,  // room for a byte
   input  wire logic [7:0] in_data,   // write side byte
   output logic            out_valid, // byte available
   input  wire logic       out_ready, // reader takes byte
   output logic [7:0]      out_data   // oldest byte
);
   logic [7:0] mem_q [2];
   logic       wr_ptr_q;
   logic       rd_ptr_q;
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic       push;
   logic       pop;

   assign push     = in_valid & in_ready & ~flush;
   assign pop      = out_valid & out_ready & ~flush;
   assign out_data = mem_q[rd_ptr_q];

   // next fill level
   always_comb begin
      cnt_d = cnt_q;
      if (flush) begin
         cnt_d = 2'h0;
      end else if (push & ~pop) begin
         cnt_d = cnt_q + 2'h1;
      end else if (pop & ~push) begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   // flags registered from the next level so both sides see flop outputs
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q     <= 2'h0;
         wr_ptr_q  <= 1'b0;
         rd_ptr_q  <= 1'b0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         cnt_q     <= cnt_d;
         in_ready  <= (cnt_d != 2'h2);
         out_valid <= (cnt_d != 2'h0);
         wr_ptr_q  <= flush ? 1'b0 : (wr_ptr_q ^ push);
         rd_ptr_q  <= flush ? 1'b0 : (rd_ptr_q ^ pop);
      end
   end

   // storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end
endmodule : sfa_buf2 // sfa_buf2
`default_nettype wire

/* rtl/sfa_flash_access.sv */
// serial flash slave front end and array access control
`default_nettype none
module sfa_flash_access #(
   parameter int unsigned TWP_CYCLES = sfa_pkg::TWP_CYCLES // program time in clocks
) (
   input  wire logic                       clk,          // 200 MHz system clock
   input  wire logic                       rst_n,        // sync reset, active low
   input  wire logic                       sck,          // serial clock pin
   input  wire logic                       cs_n,         // chip select pin
   input  wire logic                       si,           // serial data in pin
   output logic                            so,           // serial data out
   output logic                            so_oe,        // drive enable for so
   input  wire logic                       wp_n,         // write protect pin
   input  wire logic                       hold_n,       // multi pin as input
   output logic                            rb_out,       // multi pin ready level
   output logic                            rb_oe,        // multi pin drive enable
   input  wire logic                       part_large,   // strap: 2048-sector part
   input  wire logic [sfa_pkg::CFG_W-1:0]  cfg_word,     // configuration word
   output logic                            busy,         // array programming
   output logic                            standby,      // idle and deselected
   output logic                            arr_rd,       // byte read request
   output logic                            arr_wr,       // byte write request
   output logic                            arr_sram,     // request targets sram
   output logic                            arr_erase,    // erase sector pulse
   output logic                            arr_prog,     // program sector pulse
   output logic [sfa_pkg::SECT_W-1:0]      arr_sector,   // sector address
   output logic [sfa_pkg::OFF_W-1:0]       arr_offset,   // byte in sector
   output logic [7:0]                      arr_wdata,    // write byte
   input  wire logic                       arr_rvalid,   // read byte returned
   input  wire logic [7:0]                 arr_rdata,    // read byte
   output logic                            arr_rready    // buffer has room
);
   // frame states
   typedef enum logic [1:0] {
      ST_OPC  = 2'b00,
      ST_ADDR = 2'b01,
      ST_DATA = 2'b10,
      ST_SKIP = 2'b11
   } sfa_st_type;

   // range check of protected sectors
   function automatic logic prot_hit(input logic [11:0] sect,
                                     input logic [3:0] wr, input logic wd,
                                     input logic [11:0] total);
      logic [11:0] lim;
      lim = (wr == 4'hF) ? total : 12'(wr * sfa_pkg::BLK_SECT);
      if (wd) begin
         prot_hit = (sect >= 12'(total - lim));
      end else begin
         prot_hit = (sect < lim);
      end
   endfunction

   // ***************************************
   // pin synchronisers
   // ***************************************
   logic [5:0] meta_q;
   logic [5:0] sync_q;
   logic       sck_prev_q;
   logic       cs_prev_q;

   // two flops per pin before any logic looks at it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= sfa_pkg::SYNC_RST;
         sync_q <= sfa_pkg::SYNC_RST;
      end else begin
         meta_q <= {part_large, hold_n, wp_n, si, cs_n, sck};
         sync_q <= meta_q;
      end
   end

   logic sck_s, cs_s, si_s, wp_s, hold_s, large_s;
   assign {large_s, hold_s, wp_s, si_s, cs_s, sck_s} = sync_q;

   // edge history
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sck_prev_q <= 1'b0;
         cs_prev_q  <= 1'b1;
      end else begin
         sck_prev_q <= sck_s;
         cs_prev_q  <= cs_s;
      end
   end

   logic [1:0]  pin_mode;
   logic        read_edge_select;
   logic        hold_act;
   logic        armed_q;
   logic        sel;
   logic        rise_e;
   logic        fall_e;
   logic        cs_rise;
   logic [11:0] sect_total;

   assign pin_mode   = cfg_word[sfa_pkg::CFG_PIN_LSB +: 2];
   assign read_edge_select        = cfg_word[sfa_pkg::CFG_RCE];
   assign hold_act   = (pin_mode == sfa_pkg::PIN_HOLD) & ~hold_s;
   assign sel        = ~cs_s & armed_q & ~hold_act;
   assign rise_e     = sel & sck_s & ~sck_prev_q;
   assign fall_e     = sel & ~sck_s & sck_prev_q;
   assign cs_rise    = cs_s & ~cs_prev_q;
   assign sect_total = large_s ? sfa_pkg::SECT_LARGE : sfa_pkg::SECT_SMALL;

   // nothing is decoded before the first deselect edge after power-up
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else if (cs_rise) begin
         armed_q <= 1'b1;
      end
   end

   // ***************************************
   // byte assembly and frame decode
   // ***************************************
   logic [2:0]  bit_cnt_q;
   logic [6:0]  rx_q;
   logic [2:0]  byte_cnt_q;
   logic [23:0] addr_q;
   logic [7:0]  op_q;
   logic [7:0]  op_d;
   sfa_st_type  st_q;
   sfa_st_type  st_d;
   logic        byte_done;
   logic [7:0]  rx_byte;
   logic [31:0] addr_full;
   logic [11:0] new_sect;
   logic [8:0]  new_off;
   logic        is_sram_op;
   logic        is_rd_op;
   logic        is_wr_op;
   logic        addr_ok;
   logic        rd_refuse;
   logic        busy_q;

   assign byte_done  = rise_e & (bit_cnt_q == 3'h7);
   assign rx_byte    = {rx_q, si_s};
   assign addr_full  = {addr_q, rx_byte};
   assign new_sect   = {1'b0, addr_full[16 +: sfa_pkg::SECT_W]};
   assign new_off    = addr_full[sfa_pkg::OFF_W-1:0];
   assign is_sram_op = (op_q == sfa_pkg::OP_SRAM_WR) | (op_q == sfa_pkg::OP_SRAM_RD);
   assign is_rd_op   = (op_q == sfa_pkg::OP_READ) | (op_q == sfa_pkg::OP_SRAM_RD);
   assign is_wr_op   = (op_q == sfa_pkg::OP_WRITE) | (op_q == sfa_pkg::OP_SRAM_WR);
   assign addr_ok    = (new_sect < sect_total) & (new_off <= sfa_pkg::OFF_LAST);
   // sram commands skip the busy check so the buffer stays usable
   assign rd_refuse  = busy_q & ~is_sram_op;

   // next frame state on each completed byte
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      if (byte_done) begin
         case (st_q)
            ST_OPC: begin
               op_d = rx_byte;
               case (rx_byte)
                  sfa_pkg::OP_STATUS: st_d = ST_DATA;
                  sfa_pkg::OP_READ, sfa_pkg::OP_WRITE, sfa_pkg::OP_XFER,
                  sfa_pkg::OP_SRAM_WR, sfa_pkg::OP_SRAM_RD: st_d = ST_ADDR;
                  default: st_d = ST_SKIP;
               endcase
            end
            ST_ADDR: begin
               if (byte_cnt_q == sfa_pkg::ADDR_BYTES) begin
                  st_d = (addr_ok & ~rd_refuse) ? ST_DATA : ST_SKIP;
               end
            end
            default: st_d = st_q;
         endcase
      end
   end

   // frame registers; a deselect restarts the frame
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q       <= ST_OPC;
         op_q       <= 8'h00;
         bit_cnt_q  <= 3'h0;
         byte_cnt_q <= 3'h0;
         rx_q       <= 7'h00;
         addr_q     <= 24'h000000;
      end else if (cs_s) begin
         st_q       <= ST_OPC;
         bit_cnt_q  <= 3'h0;
         byte_cnt_q <= 3'h0;
      end else if (rise_e) begin
         st_q      <= st_d;
         op_q      <= op_d;
         bit_cnt_q <= bit_cnt_q + 3'h1;
         rx_q      <= rx_byte[6:0];
         if (byte_done) begin
            addr_q <= addr_full[23:0];
            if (byte_cnt_q != 3'h7) begin
               byte_cnt_q <= byte_cnt_q + 3'h1;
            end
         end
      end
   end

   // ***************************************
   // array and sram requests
   // ***************************************
   logic       outst_q;
   logic       prog_pend_q;
   logic [8:0] off_q;
   logic       wr_refuse_q;
   logic       rd_refuse_q;
   logic       buf_valid;
   logic [7:0] buf_data;
   logic       buf_pop;
   logic       enter_data;
   logic       commit;
   logic       protect;
   logic       stat_clr;

   assign enter_data = byte_done & (st_q == ST_ADDR) & (st_d == ST_DATA);
   assign protect    = ~wp_s
                     | prot_hit({1'b0, arr_sector}, cfg_word[sfa_pkg::CFG_WR_LSB +: 4],
                                cfg_word[sfa_pkg::CFG_WD], sect_total);
   assign commit     = cs_rise & (st_q == ST_DATA) & ~busy_q
                     & ((op_q == sfa_pkg::OP_WRITE) | (op_q == sfa_pkg::OP_XFER));

   // request pulses, address and data toward the array side
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         arr_rd      <= 1'b0;
         arr_wr      <= 1'b0;
         arr_erase   <= 1'b0;
         arr_prog    <= 1'b0;
         arr_sram    <= 1'b0;
         arr_sector  <= '0;
         arr_offset  <= '0;
         arr_wdata   <= 8'h00;
         off_q       <= 9'h000;
         outst_q     <= 1'b0;
         prog_pend_q <= 1'b0;
      end else begin
         arr_rd    <= 1'b0;
         arr_wr    <= 1'b0;
         arr_erase <= 1'b0;
         arr_prog  <= prog_pend_q;
         prog_pend_q <= 1'b0;
         if (arr_rvalid) begin
            outst_q <= 1'b0;
         end
         if (enter_data) begin
            arr_sector <= new_sect[sfa_pkg::SECT_W-1:0];
            arr_sram   <= is_sram_op | (op_q == sfa_pkg::OP_WRITE);
            off_q      <= new_off;
         end else if (~cs_s & (st_q == ST_DATA) & is_rd_op & ~outst_q & arr_rready) begin
            // one byte in flight at most, so the buffer never overruns
            arr_rd     <= 1'b1;
            arr_offset <= off_q;
            outst_q    <= 1'b1;
            off_q      <= (off_q == sfa_pkg::OFF_LAST) ? 9'h000 : off_q + 9'h001;
         end else if (byte_done & (st_q == ST_DATA) & is_wr_op) begin
            arr_wr     <= 1'b1;
            arr_wdata  <= rx_byte;
            arr_offset <= off_q;
            off_q      <= (off_q == sfa_pkg::OFF_LAST) ? 9'h000 : off_q + 9'h001;
         end
         if (commit & ~protect) begin
            arr_erase   <= 1'b1;
            arr_sram    <= 1'b1;
            prog_pend_q <= 1'b1;
         end
      end
   end

   // refusal flags; a new refusal beats the clear from a status read
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_refuse_q <= 1'b0;
         rd_refuse_q <= 1'b0;
      end else begin
         wr_refuse_q <= (commit & protect) | (wr_refuse_q & ~stat_clr);
         rd_refuse_q <= (byte_done & (st_q == ST_ADDR) & (byte_cnt_q == sfa_pkg::ADDR_BYTES)
                         & rd_refuse) | (rd_refuse_q & ~stat_clr);
      end
   end

   // ***************************************
   // busy timer, standby and multi pin
   // ***************************************
   logic [sfa_pkg::BUSY_W-1:0] busy_cnt_q;

   // program time counted from the program pulse
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy_q     <= 1'b0;
         busy_cnt_q <= '0;
      end else if (prog_pend_q) begin
         busy_q     <= 1'b1;
         busy_cnt_q <= sfa_pkg::BUSY_W'(TWP_CYCLES - 1);
      end else if (busy_q) begin
         if (busy_cnt_q == '0) begin
            busy_q <= 1'b0;
         end else begin
            busy_cnt_q <= busy_cnt_q - 1'b1;
         end
      end
   end

   // status and pin views of the busy state
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy    <= 1'b0;
         standby <= 1'b0;
         rb_out  <= 1'b0;
         rb_oe   <= 1'b0;
      end else begin
         busy    <= busy_q;
         standby <= cs_s & ~busy_q & ~prog_pend_q;
         rb_out  <= ~busy_q;
         rb_oe   <= (pin_mode == sfa_pkg::PIN_RB);
      end
   end

   // ***************************************
   // read data buffer and output shifter
   // ***************************************
   logic [7:0] stat_byte;
   logic [6:0] tx_q;
   logic       out_edge;
   logic       tx_load;
   logic [7:0] tx_byte;

   always_comb begin
      stat_byte = 8'h00;
      stat_byte[sfa_pkg::ST_BUSY]   = busy_q;
      stat_byte[sfa_pkg::ST_WR_REF] = wr_refuse_q;
      stat_byte[sfa_pkg::ST_RD_REF] = rd_refuse_q;
   end

   sfa_buf2 u_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .flush     (cs_s),
      .in_valid  (arr_rvalid & outst_q),
      .in_ready  (arr_rready),
      .in_data   (arr_rdata),
      .out_valid (buf_valid),
      .out_ready (buf_pop),
      .out_data  (buf_data)
   );

   // rising-edge mode loads on a byte's first rise, one half clock later
   assign out_edge = read_edge_select ? rise_e : fall_e;
   assign tx_load  = out_edge & (bit_cnt_q == 3'h0);
   assign buf_pop  = tx_load & (st_q == ST_DATA) & is_rd_op;
   // clear only once the status byte is loaded, so the read still reports the flags
   assign stat_clr = tx_load & (st_q == ST_DATA) & (op_q == sfa_pkg::OP_STATUS);
   assign tx_byte  = (st_q != ST_DATA) ? 8'hFF
                   : (op_q == sfa_pkg::OP_STATUS) ? stat_byte
                   : buf_valid ? buf_data : 8'hFF;

   // shift out msb first on the selected edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         so    <= 1'b1;
         tx_q  <= 7'h7F;
         so_oe <= 1'b0;
      end else begin
         so_oe <= ~cs_s & ~hold_act;
         if (cs_s) begin
            so   <= 1'b1;
            tx_q <= 7'h7F;
         end else if (tx_load) begin
            so   <= tx_byte[7];
            tx_q <= tx_byte[6:0];
         end else if (out_edge) begin
            so   <= tx_q[6];
            tx_q <= {tx_q[5:0], 1'b1};
         end
      end
   end
endmodule : sfa_flash_access // sfa_flash_access
`default_nettype wire

/* verif/sfa_flash_access_asserts.sv */
// port checker for the serial flash array access block
`default_nettype none
module sfa_flash_access_chk #(
   parameter int unsigned TWP_CYCLES = 50 // program time in clocks
) (
   input wire logic clk,       // system clock
   input wire logic rst_n,     // sync reset, active low
   input wire logic cs_n,      // chip select pin
   input wire logic wp_n,      // write protect pin
   input wire logic so_oe,     // serial out enable
   input wire logic rb_out,    // ready level
   input wire logic rb_oe,     // multi pin enable
   input wire logic busy,      // array programming
   input wire logic arr_rd,    // read pulse
   input wire logic arr_sram,  // sram target
   input wire logic arr_erase, // erase pulse
   input wire logic arr_prog   // program pulse
);
   int unsigned run_q;

   // length of the current busy run; any idle cycle restarts it
   always_ff @(posedge clk) begin
      if (!rst_n || !busy) run_q <= '0;
      else run_q <= run_q + 1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_oe_idle; cs_n [*6] |-> !so_oe; endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("so driven while deselected");
   property p_idle_quiet; cs_n [*8] |-> !arr_rd; endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("read while deselected");
   property p_prog_after; arr_erase |=> arr_prog; endproperty
   a_prog_after: assert property (p_prog_after) else $error("no program after erase");
   property p_busy_start; arr_prog |=> busy; endproperty
   a_busy_start: assert property (p_busy_start) else $error("busy not raised");
   property p_busy_len; $fell(busy) |-> run_q == TWP_CYCLES; endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_refuse; busy |-> !arr_erase && !(arr_rd && !arr_sram); endproperty
   a_refuse: assert property (p_refuse) else $error("array used while busy");
   property p_wp_block; !wp_n [*8] |-> !arr_erase; endproperty
   a_wp_block: assert property (p_wp_block) else $error("erase under protect pin");
   property p_rb_busy; (busy && rb_oe) [*3] |-> !rb_out; endproperty
   a_rb_busy: assert property (p_rb_busy) else $error("pin shows ready while busy");
endmodule // sfa_flash_access_chk
`default_nettype wire

/* verif/sfa_host_model.sv */
// host side model: spi master on the serial pins
`default_nettype none
module sfa_host_model (
   output logic      sck,   // serial clock, low between frames
   output logic      cs_n,  // chip select
   output logic      si,    // data to device
   input  wire logic so,    // data from device
   input  wire logic so_oe, // device drive enable
   input  wire logic read_edge_select    // device output edge select
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam realtime HALF = 62.5;

   // pins idle until the first frame
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
   end

   // select change with half a period of margin either side
   task automatic sel(input logic on);
      #HALF;
      cs_n = !on;
      #HALF;
   endtask

   // one byte msb first; a released so reads as z and never matches
   task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         si = tx[i];
         #HALF sck = 1'b1;
         if (!read_edge_select) rx[i] = so_oe ? so : 1'bz;
         #HALF sck = 1'b0;
         if (read_edge_select) rx[i] = so_oe ? so : 1'bz;
      end
      si = ~si; // no stale level left on the line
   endtask
endmodule // sfa_host_model
`default_nettype wire

/* verif/sfa_flash_access_tb_top.sv */
// self-checking bench for the serial flash array access block
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
   $display("FAIL %s exp %h got %h", n, e, g); end end
module sfa_flash_access_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned TWP = 3600; // shortened so a run stays brief
   localparam logic [10:0] PSEC [4] = '{11'h007, 11'h005, 11'h028, 11'h7FC};
   logic       clk, rst_n, wp_n, hold_n, part_large, arr_rvalid;
   logic [8:0] cfg;
   logic [7:0] arr_rdata, r, d;
   logic [7:0] sram [0:263];
   logic [10:0] s, er_sec;
   int         failures, checks_done, rd_cnt, er_cnt, seed;
   wire        sck, cs_n, si, so, so_oe, rb_out, rb_oe, busy, standby;
   wire        arr_rd, arr_wr, arr_sram, arr_erase, arr_prog, arr_rready;
   wire [10:0] arr_sector;
   wire [8:0]  arr_offset;
   wire [7:0]  arr_wdata;

   sfa_flash_access #(.TWP_CYCLES(TWP)) uut (.clk(clk), .rst_n(rst_n), .sck(sck),
      .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe), .wp_n(wp_n), .hold_n(hold_n),
      .rb_out(rb_out), .rb_oe(rb_oe), .part_large(part_large), .cfg_word(cfg),
      .busy(busy), .standby(standby), .arr_rd(arr_rd), .arr_wr(arr_wr),
      .arr_sram(arr_sram), .arr_erase(arr_erase), .arr_prog(arr_prog),
      .arr_sector(arr_sector), .arr_offset(arr_offset), .arr_wdata(arr_wdata),
      .arr_rvalid(arr_rvalid), .arr_rdata(arr_rdata), .arr_rready(arr_rready));
   sfa_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
      .read_edge_select(cfg[2]));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   function automatic logic [7:0] pat(input logic [10:0] sc, input logic [8:0] of);
      return sc[7:0] ^ of[7:0] ^ {7'h00, of[8]} ^ 8'h5A;
   endfunction

   // array and sram stand-in; answers a read in the same cycle as its pulse
   always @(posedge clk) begin
      #1;
      arr_rvalid = 1'b0;
      if (arr_rd) begin
         rd_cnt++;
         arr_rdata = arr_sram ? sram[arr_offset] : pat(arr_sector, arr_offset);
         arr_rvalid = 1'b1;
      end
      if (arr_wr) sram[arr_offset] = arr_wdata;
      if (arr_erase) begin
         er_cnt++;
         er_sec = arr_sector;
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // opcode, then sector and offset unless it is a status read
   task automatic frame(input logic [7:0] op, input logic [10:0] sc, input logic [8:0] of);
      host.sel(1'b1);
      host.xb(op, r);
      if (op != sfa_pkg::OP_STATUS) begin
         host.xb({5'h00, sc[10:8]}, r);
         host.xb(sc[7:0], r);
         host.xb({7'h00, of[8]}, r);
         host.xb(of[7:0], r);
      end
      host.xb(d, r);
   endtask
   // deselect, then give the commit time to land
   task automatic done();
      host.sel(1'b0);
      tick(20);
   endtask
   task automatic wait_idle();
      for (int n = 0; n < 5000 && busy !== 1'b0; n++) tick(1);
      `CHK("busy end", 1'b0, busy)
      tick(8);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // hang guard, far beyond the expected run
   initial begin
      #400000;
      failures++;
      tally_and_finish();
   end

   initial begin
      seed = 32'h4207E607;
      rst_n = 1'b0;
      wp_n = 1'b1;
      hold_n = 1'b1;
      part_large = 1'b0;
      arr_rvalid = 1'b0;
      arr_rdata = 8'h00;
      d = 8'h00;
      cfg = 9'h002; // ready/busy pin, no protect range
      tick(8);
      rst_n = 1'b1;
      frame(sfa_pkg::OP_READ, 11'h001, 9'h000);
      done();
      `CHK("unarmed read", 0, rd_cnt)
      // partial reads wrapping at the sector end, both output edges
      for (int k = 0; k < 2; k++) begin
         cfg[2] = k[0];
         s = 11'($random(seed) & 32'h1FF);
         frame(sfa_pkg::OP_READ, s, 9'h106);
         `CHK("read byte", pat(s, 9'h106), r)
         for (int j = 1; j < 3; j++) begin
            host.xb(8'h00, r);
            `CHK("read byte", pat(s, 9'((32'h106 + j) % 32'h108)), r)
         end
         done();
      end
      // a high sector exists only on the larger part
      for (int k = 0; k < 2; k++) begin
         part_large = k[0];
         rd_cnt = 0;
         frame(sfa_pkg::OP_READ, 11'h258, 9'h000);
         done();
         `CHK("large part read", k[0], rd_cnt != 0)
      end
      // write, then probe array and sram while it programs
      s = 11'($random(seed) & 32'h1FF);
      d = 8'($random(seed));
      er_cnt = 0;
      frame(sfa_pkg::OP_WRITE, s, 9'h000);
      done();
      `CHK("erase count", 1, er_cnt)
      `CHK("erase sector", s, er_sec)
      `CHK("busy", 1'b1, busy)
      `CHK("ready pin", 1'b0, rb_out)
      `CHK("standby", 1'b0, standby)
      rd_cnt = 0;
      frame(sfa_pkg::OP_READ, s, 9'h000);
      done();
      `CHK("read in busy", 0, rd_cnt)
      frame(sfa_pkg::OP_STATUS, 11'h000, 9'h000);
      done();
      `CHK("status", 3'h5, r[2:0])
      frame(sfa_pkg::OP_SRAM_RD, 11'h000, 9'h000);
      done();
      `CHK("sram in busy", d, r)
      wait_idle();
      `CHK("standby", 1'b1, standby)
      // protect pin against a write, protect range against both commit commands
      for (int k = 0; k < 4; k++) begin
         wp_n = (k != 0);
         cfg[7:4] = (k == 0) ? 4'h0 : 4'h1;
         cfg[3] = (k == 3);
         er_cnt = 0;
         frame((k >= 2) ? sfa_pkg::OP_XFER : sfa_pkg::OP_WRITE, PSEC[k], 9'h000);
         done();
         `CHK("protect erase", k == 2, er_cnt)
         frame(sfa_pkg::OP_STATUS, 11'h000, 9'h000);
         done();
         `CHK("write refused", k != 2, r[1])
         wait_idle();
      end
      // hold mode: output lets go of the pin while held
      cfg[1:0] = sfa_pkg::PIN_HOLD;
      host.sel(1'b1);
      tick(1);
      hold_n = 1'b0;
      tick(10);
      `CHK("held so_oe", 1'b0, so_oe)
      hold_n = 1'b1;
      tick(10);
      `CHK("so_oe", 1'b1, so_oe)
      done();
      `CHK("rb enable", 1'b0, rb_oe)
      `CHK("buffer room", 1'b1, arr_rready)
      tally_and_finish();
   end
endmodule // sfa_flash_access_tb_top

bind sfa_flash_access sfa_flash_access_chk #(.TWP_CYCLES(TWP_CYCLES)) u_chk (
   .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .wp_n(wp_n), .so_oe(so_oe), .rb_out(rb_out),
   .rb_oe(rb_oe), .busy(busy), .arr_rd(arr_rd), .arr_sram(arr_sram),
   .arr_erase(arr_erase), .arr_prog(arr_prog));
`default_nettype wire
